/* File: src/lsst_fifo.sv */
`timescale 1ns/1ps
module lsst_fifo
    import lsst_pkg::*;
#(
    parameter int W = 8,
    parameter int DEPTH = 16
)
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    lsst_stream_if.snk wr,
    lsst_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp, next_wp, rp, next_rp;
    logic [CW-1:0] cnt, next_cnt;
    logic push, pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign wr.ready = (cnt != CW'(DEPTH));
    assign rd.valid = (cnt != '0);
    assign rd.data = mem[rp];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;

    always_comb
    begin
        next_wp = push ? bump(wp) : wp;
        next_rp = pop ? bump(rp) : rp;
        next_cnt = cnt;
        if (push && !pop)
        begin
            next_cnt = cnt + 1'b1;
        end
        else if (pop && !push)
        begin
            next_cnt = cnt - 1'b1;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end
        else
        begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (push)
        begin
            mem[wp] <= wr.data;
        end
    end

    AST_FIFO_NO_OVERFLOW: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        cnt == CW'(DEPTH) |=> cnt <= CW'(DEPTH))
        else $error("fifo count above depth");
endmodule // lsst_fifo

/* File: src/lsst_pkg.sv */
package lsst_pkg;
    localparam int PIXEL_W = 12;
    localparam int PIXEL_COUNT = 1024;
    localparam int REF_PIXELS = 5;
    localparam int EFFECTIVE_PIXELS = 1002;
    localparam int LEAD_TRIGS = 88;
    localparam int INTEG_EXTRA = 48;
    localparam int FIFO_DEPTH = 16;
    localparam int START_PERIOD_MIN = 106;
    localparam int START_HIGH_MIN = 6;
    localparam int START_LOW_MIN = 100;
    localparam longint MAX_PIXEL_RATE_HZ = 64'd10_000_000;
    // fifo word fields
    localparam int FLD_DATA = 0;
    localparam int FLD_REF = PIXEL_W;
    localparam int FLD_PIX = PIXEL_W + 1;
    localparam int FLD_LAST = PIXEL_W + 2;
    localparam int WORD_W = PIXEL_W + 3;
    // reset values
    localparam logic RST_TRIG = 1'b0;
    localparam logic RST_DONE = 1'b0;

    typedef enum logic {LSST_IDLE, LSST_SHIFT} lsst_state_type;
endpackage

/* File: src/lsst_scan.sv */
// How it works
// - shifting starts first edge after start falls
// - integration equals start high plus 48
// - first pixel presented at 89th trigger
// - trigger output marks every sampling instant
// - 1024 pixels, five reference each end
// - one pixel per clock, 10 MHz limit
`timescale 1ns/1ps
module lsst_scan
    import lsst_pkg::*;
#(
    parameter int PIXELS = PIXEL_COUNT,
    parameter int REFS = REF_PIXELS,
    parameter int LEAD = LEAD_TRIGS,
    parameter int EXTRA = INTEG_EXTRA,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic scan_start_in,
    input wire logic [PIXEL_W-1:0] pixel_level_in,
    input wire logic sample_ready_in,
    output logic [$clog2(PIXELS)-1:0] pixel_addr_out,
    output logic integrating_out,
    output logic snapshot_out,
    output logic [PIXEL_W-1:0] video_out,
    output logic trig_out,
    output logic pixel_valid_out,
    output logic ref_pixel_out,
    output logic scan_done_out
);
    localparam int PXW = $clog2(PIXELS);
    localparam int LDW = $clog2(LEAD + 1);
    localparam int EXW = $clog2(EXTRA + 1);

    lsst_stream_if #(.W(WORD_W)) fin ();
    lsst_stream_if #(.W(WORD_W)) fout ();

    lsst_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_fifo (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .wr(fin.snk),
        .rd(fout.src)
    );

    logic st_q;
    logic fall;
    lsst_state_type state, next_state;
    logic [LDW-1:0] lead_cnt, next_lead_cnt;
    logic [PXW-1:0] pix_cnt, next_pix_cnt;
    logic lead_phase, is_last, is_ref, push;
    logic [WORD_W-1:0] word;

    assign fall = st_q && !scan_start_in;
    assign lead_phase = (lead_cnt < LDW'(LEAD));
    assign is_last = !lead_phase && (pix_cnt == PXW'(PIXELS - 1));
    assign is_ref = (pix_cnt < PXW'(REFS)) || (pix_cnt >= PXW'(PIXELS - REFS));
    assign pixel_addr_out = pix_cnt;

    assign fin.valid = (state == LSST_SHIFT) || (state == LSST_IDLE && fall);
    assign push = fin.valid && fin.ready;

    always_comb
    begin
        word = '0;
        if (!lead_phase)
        begin
            word[FLD_DATA +: PIXEL_W] = pixel_level_in;
            word[FLD_PIX] = 1'b1;
            word[FLD_REF] = is_ref;
            word[FLD_LAST] = is_last;
        end
    end
    assign fin.data = word;

    always_comb
    begin
        next_state = state;
        next_lead_cnt = lead_cnt;
        next_pix_cnt = pix_cnt;
        if (state == LSST_IDLE && fall)
        begin
            next_state = LSST_SHIFT;
        end
        if (push && lead_phase)
        begin
            next_lead_cnt = lead_cnt + 1'b1;
        end
        else if (push && is_last)
        begin
            next_state = LSST_IDLE;
            next_lead_cnt = '0;
            next_pix_cnt = '0;
        end
        else if (push)
        begin
            next_pix_cnt = pix_cnt + 1'b1;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            st_q <= 1'b0;
            state <= LSST_IDLE;
            lead_cnt <= '0;
            pix_cnt <= '0;
        end
        else
        begin
            st_q <= scan_start_in;
            state <= next_state;
            lead_cnt <= next_lead_cnt;
            pix_cnt <= next_pix_cnt;
        end
    end

    // integration window
    logic [EXW-1:0] ext_cnt, next_ext_cnt;
    logic next_integrating, next_snapshot;

    always_comb
    begin
        next_ext_cnt = ext_cnt;
        next_integrating = integrating_out;
        next_snapshot = 1'b0;
        if (!st_q && scan_start_in)
        begin
            next_integrating = 1'b1;
            next_ext_cnt = '0;
        end
        else if (fall)
        begin
            next_ext_cnt = EXW'(EXTRA);
        end
        else if (ext_cnt == EXW'(1))
        begin
            next_ext_cnt = '0;
            next_integrating = 1'b0;
            next_snapshot = 1'b1;
        end
        else if (ext_cnt != '0)
        begin
            next_ext_cnt = ext_cnt - 1'b1;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            ext_cnt <= '0;
            integrating_out <= 1'b0;
            snapshot_out <= 1'b0;
        end
        else
        begin
            ext_cnt <= next_ext_cnt;
            integrating_out <= next_integrating;
            snapshot_out <= next_snapshot;
        end
    end

    // output stage
    logic pop, last_q;
    logic next_trig, next_done, next_last, next_pixv, next_ref;
    logic [PIXEL_W-1:0] next_video;

    assign fout.ready = sample_ready_in;
    assign pop = fout.valid && sample_ready_in;

    always_comb
    begin
        next_video = video_out;
        next_pixv = pixel_valid_out;
        next_ref = ref_pixel_out;
        next_last = 1'b0;
        next_trig = pop;
        next_done = trig_out && last_q;
        if (pop)
        begin
            next_video = fout.data[FLD_DATA +: PIXEL_W];
            next_pixv = fout.data[FLD_PIX];
            next_ref = fout.data[FLD_REF];
            next_last = fout.data[FLD_LAST];
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            video_out <= '0;
            trig_out <= RST_TRIG;
            pixel_valid_out <= 1'b0;
            ref_pixel_out <= 1'b0;
            last_q <= 1'b0;
            scan_done_out <= RST_DONE;
        end
        else
        begin
            video_out <= next_video;
            trig_out <= next_trig;
            pixel_valid_out <= next_pixv;
            ref_pixel_out <= next_ref;
            last_q <= next_last;
            scan_done_out <= next_done;
        end
    end

    // checking helpers: triggers and pixels seen per scan
    logic [11:0] chk_trigs;
    logic [11:0] chk_pix;
    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            chk_trigs <= '0;
            chk_pix <= '0;
        end
        else if (scan_done_out)
        begin
            chk_trigs <= '0;
            chk_pix <= '0;
        end
        else if (trig_out)
        begin
            chk_trigs <= chk_trigs + 1'b1;
            chk_pix <= chk_pix + 12'(pixel_valid_out);
        end
    end

    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    AST_SHIFT_ON_FALL: assert property (
        state == LSST_IDLE && fall && fin.ready |=> state == LSST_SHIFT && lead_cnt == LDW'(1))
        else $error("shift did not start after start fell");
    AST_INTEG_LEN: assert property (
        fall && state == LSST_IDLE |-> ##1 (integrating_out && !snapshot_out) [*8] ##41 snapshot_out)
        else $error("integration window length wrong");
    AST_SNAP_ENDS_INTEG: assert property (
        snapshot_out |-> !integrating_out && $past(integrating_out))
        else $error("snapshot without end of integration");
    AST_FIRST_PIXEL_89: assert property (
        trig_out && pixel_valid_out && chk_pix == '0 |-> chk_trigs == 12'(LEAD))
        else $error("first pixel not on 89th trigger");
    AST_LEAD_NOT_PIXEL: assert property (
        trig_out && chk_trigs < 12'(LEAD) |-> !pixel_valid_out)
        else $error("pixel presented during lead-in");
    AST_TRIG_ON_READY: assert property (
        trig_out |-> $past(sample_ready_in))
        else $error("trigger without sampler ready");
    AST_PIXEL_COUNT: assert property (
        scan_done_out |-> chk_pix == 12'(PIXELS))
        else $error("scan pixel count wrong");
    AST_REF_FLAG: assert property (
        trig_out && pixel_valid_out && chk_pix < 12'(REFS) |-> ref_pixel_out)
        else $error("reference pixel not flagged");
    AST_ONE_PER_CLOCK: assert property (
        state == LSST_SHIFT && !$past(state == LSST_IDLE) |=> pix_cnt == $past(pix_cnt)
            || pix_cnt == $past(pix_cnt) + 1'b1 || pix_cnt == '0)
        else $error("more than one pixel per clock");
    AST_DONE_ONE_CYCLE: assert property (
        scan_done_out |-> $past(trig_out) && !$past(scan_done_out))
        else $error("end of scan pulse malformed");

    COV_SCAN_DONE: cover property (scan_done_out);
    COV_FIFO_FULL: cover property (state == LSST_SHIFT && !fin.ready);
    COV_SNAPSHOT: cover property (snapshot_out);
    COV_REF_PIXEL: cover property (trig_out && ref_pixel_out);
endmodule // lsst_scan

/* File: src/lsst_stream_if.sv */
`timescale 1ns/1ps
interface lsst_stream_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

/* File: tb/lsst_ctrl_model.sv */
`timescale 1ns/1ps
module lsst_ctrl_model
    import lsst_pkg::*;
#(
    parameter int AW = 5
)
(
    input wire logic clock_in,
    input wire logic go_in,
    input wire logic [7:0] high_in,
    input wire logic [1:0] mode_in,
    input wire logic [PIXEL_W-1:0] salt_in,
    input wire logic [AW-1:0] pixel_addr_in,
    output logic scan_start_out,
    output logic sample_ready_out,
    output logic [PIXEL_W-1:0] pixel_level_out,
    output logic busy_out,
    output logic first_scan_out
);
    int seed = 46859;
    int cnt = 0;
    int low = START_LOW_MIN;
    int scans = 0;
    initial scan_start_out = 1'b0;
    initial sample_ready_out = 1'b1;
    assign pixel_level_out = salt_in ^ PIXEL_W'(pixel_addr_in);
    assign busy_out = scan_start_out || (low < START_LOW_MIN);
    assign first_scan_out = (scans < 2);
    always @(negedge clock_in)
    begin
        if (go_in && !busy_out)
        begin
            scan_start_out <= 1'b1;
            cnt <= (high_in < START_HIGH_MIN) ? START_HIGH_MIN : int'(high_in);
            scans <= scans + 1;
        end
        else if (scan_start_out)
        begin
            if (cnt <= 1)
            begin
                scan_start_out <= 1'b0;
                low <= 0;
            end
            cnt <= cnt - 1;
        end
        else if (low < START_LOW_MIN)
            low <= low + 1;
        case (mode_in)
            2'd0: sample_ready_out <= 1'b1;
            2'd1: sample_ready_out <= ($random(seed) % 3) != 0;
            default: sample_ready_out <= (low >= 60);
        endcase
    end
endmodule // lsst_ctrl_model

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import lsst_pkg::*;
    localparam int NPIX = 32;
    localparam int NLEAD = 8;
    localparam int AW = 5;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic go = 1'b0;
    logic [7:0] high = 8'h06;
    logic [1:0] mode = 2'h0;
    logic [PIXEL_W-1:0] salt = 12'h000;
    logic scan_start_in, sample_ready_in, busy, first_scan;
    logic [PIXEL_W-1:0] pixel_level_in, video_out;
    logic [AW-1:0] pixel_addr_out;
    logic integrating_out, snapshot_out, trig_out, pixel_valid_out, ref_pixel_out, scan_done_out;
    int failures = 0;
    int n_checks = 0;
    int seed = 46859;
    int k = 1000;
    logic prev_st = 1'b0;
    logic done_pend = 1'b0;
    logic [14:0] exp_q[$];
    logic [14:0] e;
    lsst_scan #(.PIXELS(NPIX), .LEAD(NLEAD)) lsst_scan_i (.clock_in(clock_in),
        .sys_rst_in(sys_rst_in), .scan_start_in(scan_start_in),
        .pixel_level_in(pixel_level_in), .sample_ready_in(sample_ready_in),
        .pixel_addr_out(pixel_addr_out), .integrating_out(integrating_out),
        .snapshot_out(snapshot_out), .video_out(video_out), .trig_out(trig_out),
        .pixel_valid_out(pixel_valid_out), .ref_pixel_out(ref_pixel_out),
        .scan_done_out(scan_done_out));
    lsst_ctrl_model #(.AW(AW)) lsst_ctrl_model_i (.clock_in(clock_in), .go_in(go),
        .high_in(high), .mode_in(mode), .salt_in(salt), .pixel_addr_in(pixel_addr_out),
        .scan_start_out(scan_start_in), .sample_ready_out(sample_ready_in),
        .pixel_level_out(pixel_level_in), .busy_out(busy), .first_scan_out(first_scan));
    initial forever #2 clock_in = ~clock_in;
    task check(input logic [31:0] seen, input logic [31:0] expd);
        n_checks++;
        if (seen !== expd)
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, seen, expd);
        end
    endtask
    task summarize;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task scan(input int h, input logic [1:0] m);
        logic [PIXEL_W-1:0] s;
        int t;
        s = PIXEL_W'($random(seed));
        while (busy) @(negedge clock_in);
        for (int i = 0; i < NLEAD; i++) exp_q.push_back(15'h0000);
        for (int i = 0; i < NPIX; i++)
            exp_q.push_back({i == NPIX - 1, 1'b1, i < REF_PIXELS || i >= NPIX - REF_PIXELS,
                s ^ PIXEL_W'(i)});
        mode <= m;
        salt <= s;
        high <= 8'(h);
        go <= 1'b1;
        @(negedge clock_in);
        go <= 1'b0;
        t = 0;
        while (exp_q.size() != 0 && t < 5000)
        begin
            @(negedge clock_in);
            t++;
        end
        check(exp_q.size(), 32'h0);
        exp_q.delete();
        repeat (3) @(negedge clock_in);
    endtask
    // output monitor, one look per cycle at the falling edge
    always @(negedge clock_in)
    begin
        if (!sys_rst_in)
        begin
            k = (prev_st && !scan_start_in) ? 1 : k + 1;
            prev_st = scan_start_in;
            check(integrating_out, scan_start_in || k <= INTEG_EXTRA);
            check(snapshot_out, k == INTEG_EXTRA + 1);
            if (mode == 2'd0 && k <= NLEAD + NPIX + 2)
                check(trig_out, k >= 2 && k < NLEAD + NPIX + 2);
            check(scan_done_out, done_pend);
            done_pend = 1'b0;
            if (trig_out === 1'b1)
            begin
                if (exp_q.size() == 0)
                    check(trig_out, 1'b0);
                else
                begin
                    e = exp_q.pop_front();
                    check(pixel_valid_out, e[13]);
                    check(ref_pixel_out, e[12]);
                    if (!first_scan) check(video_out, e[11:0]);
                    done_pend = e[14];
                end
            end
        end
    end
    initial
    begin
        #(4 * 20000);
        failures++;
        summarize();
    end
    initial
    begin
        repeat (4) @(negedge clock_in);
        sys_rst_in <= 1'b0;
        scan(6, 2'd0);
        scan(6, 2'd0);
        scan(60, 2'd1);
        scan(20, 2'd2);
        for (int i = 0; i < 3; i++) scan(6 + ($unsigned($random(seed)) % 35), 2'd1);
        scan(6, 2'd0);
        summarize();
    end
endmodule // testbench
